// ===== src/bisig_dev.sv
// Bridge interrupt signalling: device end with Wishbone register slave
// Summary of operation
// - Local interrupt follows interrupt mask register
// - MSI-received decode used only in Root Port
// - MSI enabled: request sends MSI memory write
// - Request rising edge, sampled on bridge clock
// - MSI write carries Root Port configured address/data
// - Request honoured only in Endpoint mode
// - Five-bit vector sent in MSI write
// - Unallocated vector bits ignored
// - Requested vectors fill Multiple Message Capable
// - Multiple Message Enable copied to width output
// - User logic supplies vector priority scheme
// - Legacy INTA only when interrupt pin set
// - Rise sends Assert_INTA, fall sends Deassert_INTA
// - User drives legacy request on bridge clock
// - Endpoint malformed TLP sends fatal error message
// - Root Port discards poisoned TLP, sets flag
// - Poisoned memory request pulses master poison strobe, only in Root Port
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module bisig_dev
	import bisig_pkg::*;
#(
	parameter bit         ROOT_COMPLEX_SELECT = 1'b0, // 1: Root Port mode
	parameter bit         INTERRUPT_PIN       = 1'b1, // 1: INTA selected
	parameter logic [2:0] NUM_MSI_REQ         = 3'h5  // log2 of requested vectors
)(
	input  wire logic   sys_clk_i, // Clock, 200 MHz
	input  wire logic   nrst_i,    // Sync reset, active low
	bisig_if.dev        link,      // Link to partner end
	input  wire logic        wb_cyc_i,  // Wishbone cycle
	input  wire logic        wb_stb_i,  // Wishbone strobe
	input  wire logic        wb_we_i,   // Wishbone write enable
	input  wire logic [7:0]  wb_adr_i,  // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,  // Wishbone byte select
	input  wire logic [31:0] wb_dat_i,  // Wishbone write data
	output logic [31:0]      wb_dat_o,  // Wishbone read data
	output logic             wb_ack_o,  // Wishbone acknowledge
	output logic             irq_o      // Local interrupt output
);
	typedef enum logic {TX_IDLE, TX_BUSY} bisig_tx_t;

	// Mask of vector bits covered by the allocated count
	function automatic logic [4:0] vec_mask(input logic [2:0] mme);
		logic [4:0] m;
		m = 5'h00;
		if (mme <= BISIG_MME_MAX) begin
			m = 5'((6'h01 << mme) - 6'h01);
		end
		return m;
	endfunction

	localparam bit EP_MODE = !ROOT_COMPLEX_SELECT;

	// ----------------------------------------
	// Request edge detection
	// ----------------------------------------
	logic req_rise;
	logic req_level;

	bisig_edge u_edge (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.sig_i     (link.intx_msi_req),
		.rise_o    (req_rise),
		.fall_o    (),
		.level_o   (req_level)
	);

	// ----------------------------------------
	// Message control and MSI status
	// ----------------------------------------
	logic       msi_on;
	logic       legacy_on;
	logic [2:0] vec_width;
	logic [2:0] next_vec_width;

	assign msi_on    = EP_MODE && link.cfg_msi_enable;
	assign legacy_on = EP_MODE && INTERRUPT_PIN && !link.cfg_msi_enable;

	always_comb begin
		next_vec_width = link.cfg_mme;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			vec_width <= 3'h0;
		end else begin
			vec_width <= next_vec_width;
		end
	end

	assign link.msi_en        = msi_on;
	assign link.msi_vec_width = vec_width;
	always_comb begin
		link.msg_ctrl = 16'h0000;
		link.msg_ctrl[BISIG_MC_EN] = link.cfg_msi_enable;
		link.msg_ctrl[BISIG_MC_MMC_LO +: 3] = NUM_MSI_REQ;
		link.msg_ctrl[BISIG_MC_MME_LO +: 3] = link.cfg_mme;
	end

	// ----------------------------------------
	// Pending events and message transmitter
	// ----------------------------------------
	bisig_tx_t       tx_state;
	bisig_tx_t       next_tx_state;
	logic            msi_pend;
	logic            next_msi_pend;
	logic [4:0]      msi_vec;
	logic [4:0]      next_msi_vec;
	logic            fatal_pend;
	logic            next_fatal_pend;
	logic            inta_sent;
	logic            next_inta_sent;
	logic            inta_busy;
	logic            next_inta_busy;
	bisig_tlp_kind_t tlp_kind;
	bisig_tlp_kind_t next_tlp_kind;
	logic [31:0]     tlp_addr;
	logic [31:0]     next_tlp_addr;
	logic [15:0]     tlp_data;
	logic [15:0]     next_tlp_data;
	logic            msi_take;
	logic            fatal_set;

	// Input ignored in Root Port mode
	assign msi_take  = req_rise && msi_on;
	assign fatal_set = EP_MODE && link.rx_valid && link.rx_malformed && link.cfg_err_rep;

	always_comb begin
		next_tx_state   = tx_state;
		next_tlp_kind   = tlp_kind;
		next_tlp_addr   = tlp_addr;
		next_tlp_data   = tlp_data;
		next_inta_sent  = inta_sent;
		next_inta_busy  = inta_busy;
		next_msi_pend   = msi_pend;
		next_msi_vec    = msi_vec;
		next_fatal_pend = fatal_pend;
		case (tx_state)
			TX_IDLE: begin
				if (fatal_pend) begin
					next_tlp_kind   = BISIG_TLP_FATAL_ERR;
					next_fatal_pend = 1'b0;
					next_tx_state   = TX_BUSY;
				end else if (msi_pend) begin
					next_tlp_kind = BISIG_TLP_MSI_WR;
					next_tlp_addr = link.cfg_msi_addr;
					next_tlp_data = {link.cfg_msi_data[15:5],
						(link.cfg_msi_data[4:0] & ~vec_mask(vec_width)) | msi_vec};
					next_msi_pend = 1'b0;
					next_tx_state = TX_BUSY;
				end else if (legacy_on && (req_level != inta_sent)) begin
					// Level compare keeps the link state right even if edges bunch up
					next_tlp_kind  = req_level ? BISIG_TLP_ASSERT_INTA : BISIG_TLP_DEASSERT_INTA;
					next_inta_sent = req_level;
					next_inta_busy = 1'b1;
					next_tx_state  = TX_BUSY;
				end
			end
			TX_BUSY: begin
				if (link.tlp_ready) begin
					next_tx_state  = TX_IDLE;
					next_inta_busy = 1'b0;
				end
			end
			default: begin
				next_tx_state = TX_IDLE;
			end
		endcase
		// New events win over the clear of their pending bit
		if (msi_take) begin
			next_msi_pend = 1'b1;
			next_msi_vec  = link.msi_vec_num & vec_mask(vec_width);
		end
		if (fatal_set) begin
			next_fatal_pend = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			tx_state   <= TX_IDLE;
			tlp_kind   <= BISIG_TLP_MSI_WR;
			tlp_addr   <= 32'h00000000;
			tlp_data   <= 16'h0000;
			inta_sent  <= 1'b0;
			inta_busy  <= 1'b0;
			msi_pend   <= 1'b0;
			msi_vec    <= 5'h00;
			fatal_pend <= 1'b0;
		end else begin
			tx_state   <= next_tx_state;
			tlp_kind   <= next_tlp_kind;
			tlp_addr   <= next_tlp_addr;
			tlp_data   <= next_tlp_data;
			inta_sent  <= next_inta_sent;
			inta_busy  <= next_inta_busy;
			msi_pend   <= next_msi_pend;
			msi_vec    <= next_msi_vec;
			fatal_pend <= next_fatal_pend;
		end
	end

	assign link.tlp_valid = (tx_state == TX_BUSY);
	assign link.tlp_kind  = tlp_kind;
	assign link.tlp_addr  = tlp_addr;
	assign link.tlp_data  = tlp_data;

	// ----------------------------------------
	// Received TLP errors (Root Port mode)
	// ----------------------------------------
	logic poison_hit;
	logic mp_strobe;
	logic next_mp_strobe;

	// Poisoned TLPs are dropped here: nothing is forwarded toward AXI
	assign poison_hit = ROOT_COMPLEX_SELECT && link.rx_valid && link.rx_poison;

	always_comb begin
		next_mp_strobe = poison_hit && link.rx_memreq;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			mp_strobe <= 1'b0;
		end else begin
			mp_strobe <= next_mp_strobe;
		end
	end

	assign link.mp_strobe = mp_strobe;

	// ----------------------------------------
	// Wishbone registers and local interrupt
	// ----------------------------------------
	logic [BISIG_DEC_W-1:0] decode;
	logic [BISIG_DEC_W-1:0] next_decode;
	logic [BISIG_DEC_W-1:0] mask;
	logic [BISIG_DEC_W-1:0] next_mask;
	logic [BISIG_DEC_W-1:0] dec_set;
	logic [31:0]            next_dat;
	logic                   next_ack;
	logic                   wr_lo;

	assign wr_lo = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];

	always_comb begin
		dec_set = '0;
		dec_set[BISIG_BIT_MPOISON] = poison_hit;
		dec_set[BISIG_BIT_MSI_RX]  = ROOT_COMPLEX_SELECT && link.rx_valid && link.rx_msi;
		dec_set[BISIG_BIT_FATAL]   = fatal_set;
		next_decode = decode;
		next_mask   = mask;
		if (wr_lo && wb_adr_i == BISIG_ADR_DECODE) begin
			next_decode = decode & ~wb_dat_i[BISIG_DEC_W-1:0];
		end
		if (wr_lo && wb_adr_i == BISIG_ADR_MASK) begin
			next_mask = wb_dat_i[BISIG_DEC_W-1:0];
		end
		next_decode = next_decode | dec_set;
		next_ack    = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_dat    = 32'h00000000;
		case (wb_adr_i)
			BISIG_ADR_DECODE: next_dat[BISIG_DEC_W-1:0] = decode;
			BISIG_ADR_MASK:   next_dat[BISIG_DEC_W-1:0] = mask;
			BISIG_ADR_STATUS: next_dat[7:0] = {inta_busy, inta_sent, vec_width, msi_on,
			                                   legacy_on, ROOT_COMPLEX_SELECT};
			default:          next_dat = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			decode   <= BISIG_DEC_RST;
			mask     <= BISIG_MASK_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			irq_o    <= 1'b0;
		end else begin
			decode   <= next_decode;
			mask     <= next_mask;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			irq_o    <= |(next_decode & next_mask);
		end
	end
endmodule

// ===== src/bisig_pkg.sv
// Shared constants and types for the bridge interrupt signalling block
package bisig_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] BISIG_ADR_DECODE = 8'h00;
	localparam logic [7:0] BISIG_ADR_MASK   = 8'h04;
	localparam logic [7:0] BISIG_ADR_STATUS = 8'h08;

	// ----------------------------------------
	// Decode / mask bit positions
	// ----------------------------------------
	localparam int BISIG_DEC_W       = 3;
	localparam int BISIG_BIT_MPOISON = 0;
	localparam int BISIG_BIT_MSI_RX  = 1;
	localparam int BISIG_BIT_FATAL   = 2;
	localparam logic [BISIG_DEC_W-1:0] BISIG_DEC_RST  = 3'h0;
	localparam logic [BISIG_DEC_W-1:0] BISIG_MASK_RST = 3'h0;

	// ----------------------------------------
	// MSI message control layout
	// ----------------------------------------
	localparam int BISIG_MC_EN     = 0;
	localparam int BISIG_MC_MMC_LO = 1;
	localparam int BISIG_MC_MME_LO = 4;
	localparam logic [2:0] BISIG_MME_MAX = 3'h5;

	// ----------------------------------------
	// Outgoing message kinds
	// ----------------------------------------
	typedef enum logic [1:0] {
		BISIG_TLP_MSI_WR,
		BISIG_TLP_ASSERT_INTA,
		BISIG_TLP_DEASSERT_INTA,
		BISIG_TLP_FATAL_ERR
	} bisig_tlp_kind_t;
endpackage

// ===== src/bisig_if.sv
// Link between the bridge end and its partner end
`timescale 1ns/1ps
interface bisig_if;
	import bisig_pkg::*;
	logic            intx_msi_req;   // Shared request, user to bridge
	logic [4:0]      msi_vec_num;    // MSI vector number
	logic            msi_en;         // MSI functionality enabled
	logic [2:0]      msi_vec_width;  // Allocated vector code
	logic [15:0]     msg_ctrl;       // Message control register view
	logic [31:0]     cfg_msi_addr;   // Root Port configured address
	logic [15:0]     cfg_msi_data;   // Root Port configured data
	logic [2:0]      cfg_mme;        // Multiple Message Enable
	logic            cfg_msi_enable; // MSI enable bit
	logic            cfg_err_rep;    // Error reporting enable
	logic            tlp_valid;      // Outgoing message valid
	logic            tlp_ready;      // Outgoing message accepted
	bisig_tlp_kind_t tlp_kind;       // Outgoing message kind
	logic [31:0]     tlp_addr;       // MSI write address
	logic [15:0]     tlp_data;       // MSI write data
	logic            rx_valid;       // Received TLP event
	logic            rx_poison;      // Poison bit of received TLP
	logic            rx_memreq;      // Received TLP is a memory request
	logic            rx_malformed;   // Received TLP malformed
	logic            rx_msi;         // MSI received (Root Port mode)
	logic            mp_strobe;      // Master poison strobe

	modport dev (
		input  intx_msi_req, msi_vec_num, cfg_msi_addr, cfg_msi_data, cfg_mme, cfg_msi_enable,
		       cfg_err_rep, tlp_ready, rx_valid, rx_poison, rx_memreq, rx_malformed, rx_msi,
		output msi_en, msi_vec_width, msg_ctrl, tlp_valid, tlp_kind, tlp_addr, tlp_data, mp_strobe
	);
	modport host (
		output intx_msi_req, msi_vec_num, cfg_msi_addr, cfg_msi_data, cfg_mme, cfg_msi_enable,
		       cfg_err_rep, tlp_ready, rx_valid, rx_poison, rx_memreq, rx_malformed, rx_msi,
		input  msi_en, msi_vec_width, msg_ctrl, tlp_valid, tlp_kind, tlp_addr, tlp_data, mp_strobe
	);
endinterface

// ===== src/bisig_edge.sv
// Edge detector for the shared interrupt request
`timescale 1ns/1ps
module bisig_edge
	import bisig_pkg::*;
(
	input  wire logic sys_clk_i, // Clock
	input  wire logic nrst_i,    // Sync reset, active low
	input  wire logic sig_i,     // Same-clock request level
	output logic      rise_o,    // Rising edge pulse
	output logic      fall_o,    // Falling edge pulse
	output logic      level_o    // Registered level
);
	logic prev;
	logic next_prev;

	always_comb begin
		next_prev = sig_i;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end

	assign rise_o  = sig_i & ~prev;
	assign fall_o  = ~sig_i & prev;
	assign level_o = prev;
endmodule

// ===== src/bisig_host.sv
// Bridge interrupt signalling: user logic and Root Port configuration end
`timescale 1ns/1ps
module bisig_host
	import bisig_pkg::*;
(
	input  wire logic        sys_clk_i,      // Clock, 200 MHz
	input  wire logic        nrst_i,         // Sync reset, active low
	bisig_if.host            link,           // Link to the bridge
	input  wire logic [31:0] user_pend_i,    // Pending MSI vectors
	input  wire logic        user_intx_i,    // Legacy interrupt level
	input  wire logic [31:0] rp_msi_addr_i,  // Root Port MSI address
	input  wire logic [15:0] rp_msi_data_i,  // Root Port MSI data
	input  wire logic [2:0]  rp_mme_i,       // Root Port vector allocation
	input  wire logic        rp_msi_en_i,    // Root Port MSI enable
	input  wire logic        rp_err_rep_i,   // Root Port error reporting
	input  wire logic        rx_valid_i,     // Rx event
	input  wire logic        rx_poison_i,    // Rx poisoned
	input  wire logic        rx_memreq_i,    // Rx memory request
	input  wire logic        rx_malformed_i, // Rx malformed
	input  wire logic        rx_msi_i,       // MSI received
	input  wire logic        tlp_ready_i,    // Accept outgoing message
	output logic             tlp_seen_o,     // Message accepted
	output bisig_tlp_kind_t  tlp_kind_o,     // Accepted message kind
	output logic [31:0]      tlp_addr_o,     // Accepted MSI address
	output logic [15:0]      tlp_data_o,     // Accepted MSI data
	output logic             served_o,       // MSI vector issued
	output logic [4:0]       served_vec_o    // Vector issued
);
	typedef enum logic [1:0] {H_IDLE, H_HIGH, H_LOW} bisig_host_t;

	// ----------------------------------------
	// Root Port configuration and rx events
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			link.cfg_msi_addr   <= 32'h00000000;
			link.cfg_msi_data   <= 16'h0000;
			link.cfg_mme        <= 3'h0;
			link.cfg_msi_enable <= 1'b0;
			link.cfg_err_rep    <= 1'b0;
			link.rx_valid       <= 1'b0;
			link.rx_poison      <= 1'b0;
			link.rx_memreq      <= 1'b0;
			link.rx_malformed   <= 1'b0;
			link.rx_msi         <= 1'b0;
		end else begin
			link.cfg_msi_addr   <= rp_msi_addr_i;
			link.cfg_msi_data   <= rp_msi_data_i;
			link.cfg_mme        <= rp_mme_i;
			link.cfg_msi_enable <= rp_msi_en_i;
			link.cfg_err_rep    <= rp_err_rep_i;
			link.rx_valid       <= rx_valid_i;
			link.rx_poison      <= rx_poison_i;
			link.rx_memreq      <= rx_memreq_i;
			link.rx_malformed   <= rx_malformed_i;
			link.rx_msi         <= rx_msi_i;
		end
	end

	// ----------------------------------------
	// Vector priority and request pulses
	// ----------------------------------------
	bisig_host_t state;
	bisig_host_t next_state;
	logic        req;
	logic        next_req;
	logic [4:0]  vec;
	logic [4:0]  next_vec;
	logic        pick_ok;
	logic [4:0]  pick;

	// Lowest numbered pending vector wins
	always_comb begin
		pick_ok = 1'b0;
		pick    = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (user_pend_i[i]) begin
				pick_ok = 1'b1;
				pick    = 5'(i);
			end
		end
	end

	always_comb begin
		next_state = state;
		next_req   = req;
		next_vec   = vec;
		case (state)
			H_IDLE: begin
				if (link.msi_en) begin
					if (pick_ok) begin
						next_vec   = pick;
						next_req   = 1'b1;
						next_state = H_HIGH;
					end else begin
						next_req = 1'b0;
					end
				end else begin
					next_req = user_intx_i;
				end
			end
			H_HIGH: begin
				next_req   = 1'b0;
				next_state = H_LOW;
			end
			H_LOW: begin
				next_state = H_IDLE;
			end
			default: begin
				next_state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state <= H_IDLE;
			req   <= 1'b0;
			vec   <= 5'h00;
		end else begin
			state <= next_state;
			req   <= next_req;
			vec   <= next_vec;
		end
	end

	assign link.intx_msi_req = req;
	assign link.msi_vec_num  = vec;
	assign served_o          = (state == H_HIGH);
	assign served_vec_o      = vec;

	// ----------------------------------------
	// Outgoing message sink
	// ----------------------------------------
	assign link.tlp_ready = tlp_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			tlp_seen_o <= 1'b0;
			tlp_kind_o <= BISIG_TLP_MSI_WR;
			tlp_addr_o <= 32'h00000000;
			tlp_data_o <= 16'h0000;
		end else begin
			tlp_seen_o <= link.tlp_valid && tlp_ready_i;
			if (link.tlp_valid && tlp_ready_i) begin
				tlp_kind_o <= link.tlp_kind;
				tlp_addr_o <= link.tlp_addr;
				tlp_data_o <= link.tlp_data;
			end
		end
	end
endmodule

// ===== test/bisig_monitor.sv
// Link checks between the two ends
`timescale 1ns/1ps
module bisig_monitor
	import bisig_pkg::*;
#(
	parameter bit         ROOT_COMPLEX_SELECT = 1'b0, // 1: Root Port mode
	parameter logic [2:0] NUM_MSI_REQ         = 3'h5  // log2 of requested vectors
)(
	input wire logic            sys_clk_i,      // Clock
	input wire logic            nrst_i,         // Sync reset, active low
	input wire logic            intx_msi_req,   // Shared request
	input wire logic            msi_en,         // MSI enabled
	input wire logic [2:0]      msi_vec_width,  // Width code
	input wire logic [15:0]     msg_ctrl,       // Msg control
	input wire logic [31:0]     cfg_msi_addr,   // Cfg address
	input wire logic [15:0]     cfg_msi_data,   // Cfg data
	input wire logic [2:0]      cfg_mme,        // Enable field
	input wire logic            cfg_msi_enable, // MSI enable bit
	input wire logic            cfg_err_rep,    // Error reporting
	input wire logic            tlp_valid,      // Message valid
	input wire logic            tlp_ready,      // Message accepted
	input wire bisig_tlp_kind_t tlp_kind,       // Message kind
	input wire logic [31:0]     tlp_addr,       // MSI address
	input wire logic [15:0]     tlp_data,       // MSI data
	input wire logic            rx_valid,       // Rx event
	input wire logic            rx_malformed    // Rx malformed
);
	logic [4:0] vmask;

	// Reserved width codes leave no vector bit in the data
	always_comb begin
		vmask = (msi_vec_width <= BISIG_MME_MAX) ? 5'((6'h1 << msi_vec_width) - 6'h1) : 5'h0;
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence msi_rise;  $rose(intx_msi_req) && msi_en;  endsequence
	sequence intx_rise; $rose(intx_msi_req) && !msi_en; endsequence
	sequence intx_fall; $fell(intx_msi_req) && !msi_en; endsequence
	sequence msi_sent;  tlp_valid && tlp_kind == BISIG_TLP_MSI_WR; endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_msi_after_rise: assert property (msi_rise |-> ##[1:40] msi_sent)
		else $error("MSI write missing");
	chk_msi_addr_data: assert property (msi_sent |-> tlp_addr == cfg_msi_addr && tlp_data[15:5] == cfg_msi_data[15:5])
		else $error("MSI address or data wrong");
	chk_vec_bits_kept: assert property (msi_sent |-> (tlp_data[4:0] & ~vmask) == (cfg_msi_data[4:0] & ~vmask))
		else $error("Unallocated vector bits sent");
	chk_msg_stands: assert property (tlp_valid && !tlp_ready |=> tlp_valid && $stable(tlp_kind)
		&& $stable(tlp_addr) && $stable(tlp_data)) else $error("Message changed early");
	chk_mmc_field: assert property (msg_ctrl[3:1] == NUM_MSI_REQ && msg_ctrl[6:4] == cfg_mme)
		else $error("Message control wrong");
	chk_width_copy: assert property ($changed(cfg_mme) |=> msi_vec_width == $past(cfg_mme))
		else $error("Vector width wrong");
	chk_msi_en_gate: assert property (msi_en == (cfg_msi_enable && !ROOT_COMPLEX_SELECT))
		else $error("MSI enable wrong");
	chk_assert_inta: assert property (intx_rise |-> ##[1:40] (tlp_valid && tlp_kind == BISIG_TLP_ASSERT_INTA))
		else $error("Assert message missing");
	chk_deassert_inta: assert property (intx_fall |-> ##[1:40] (tlp_valid && tlp_kind == BISIG_TLP_DEASSERT_INTA))
		else $error("Deassert message missing");
	chk_fatal_sent: assert property (rx_valid && rx_malformed && cfg_err_rep |-> ##[1:40]
		(tlp_valid && tlp_kind == BISIG_TLP_FATAL_ERR)) else $error("Fatal message missing");
endmodule

// ===== test/testbench.sv
// Bench for Endpoint and Root Port signalling ends
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: %h %h", $time, g, e); end end
module testbench;
	import bisig_pkg::*;
	logic        sys_clk_i = 1'b0, nrst_i = 1'b0, sel_rc = 1'b0;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, user_pend_i = 32'h0, rp_msi_addr_i = 32'h0, ep_dat, rc_dat, ep_addr;
	logic        user_intx_i = 1'b0, rp_msi_en_i = 1'b0, rp_err_rep_i = 1'b0, tlp_ready_i = 1'b0;
	logic        rx_valid_i = 1'b0, rx_poison_i = 1'b0, rx_memreq_i = 1'b0, rx_malformed_i = 1'b0, rx_msi_i = 1'b0;
	logic [15:0] rp_msi_data_i = 16'h0, ep_data;
	logic [2:0]  rp_mme_i = 3'h0;
	logic        ep_ack, rc_ack, ep_irq, rc_irq, ep_seen, rc_seen, ep_served;
	bisig_tlp_kind_t ep_kind;
	logic [50:0] tq[$];
	logic [63:0] rq[$];
	logic [50:0] e;
	logic [63:0] r;
	logic [4:0]  m;
	int          n_fail = 0, n_compared = 0, n_rc_seen = 0, n_strobe = 0, v;

	bisig_if ep_link();
	bisig_if rc_link();
	bisig_dev #(.ROOT_COMPLEX_SELECT(1'b0)) bisig_dev_i (.sys_clk_i, .nrst_i, .link(ep_link), .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(ep_dat), .wb_ack_o(ep_ack), .irq_o(ep_irq));
	bisig_dev #(.ROOT_COMPLEX_SELECT(1'b1), .INTERRUPT_PIN(1'b0)) bisig_dev_rc_i (.sys_clk_i, .nrst_i, .link(rc_link),
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(rc_dat), .wb_ack_o(rc_ack), .irq_o(rc_irq));
	bisig_host bisig_host_i (.sys_clk_i, .nrst_i, .link(ep_link), .user_pend_i, .user_intx_i, .rp_msi_addr_i,
		.rp_msi_data_i, .rp_mme_i, .rp_msi_en_i, .rp_err_rep_i, .rx_valid_i, .rx_poison_i, .rx_memreq_i, .rx_malformed_i,
		.rx_msi_i, .tlp_ready_i, .tlp_seen_o(ep_seen), .tlp_kind_o(ep_kind), .tlp_addr_o(ep_addr), .tlp_data_o(ep_data),
		.served_o(ep_served), .served_vec_o());
	bisig_host bisig_host_rc_i (.sys_clk_i, .nrst_i, .link(rc_link), .user_pend_i, .user_intx_i, .rp_msi_addr_i,
		.rp_msi_data_i, .rp_mme_i, .rp_msi_en_i, .rp_err_rep_i, .rx_valid_i, .rx_poison_i, .rx_memreq_i, .rx_malformed_i,
		.rx_msi_i, .tlp_ready_i, .tlp_seen_o(rc_seen), .tlp_kind_o(), .tlp_addr_o(), .tlp_data_o(), .served_o(),
		.served_vec_o());
	bisig_monitor bisig_monitor_i (.sys_clk_i, .nrst_i, .intx_msi_req(ep_link.intx_msi_req), .msi_en(ep_link.msi_en),
		.msi_vec_width(ep_link.msi_vec_width), .msg_ctrl(ep_link.msg_ctrl), .cfg_msi_addr(ep_link.cfg_msi_addr),
		.cfg_msi_data(ep_link.cfg_msi_data), .cfg_mme(ep_link.cfg_mme), .cfg_msi_enable(ep_link.cfg_msi_enable),
		.cfg_err_rep(ep_link.cfg_err_rep), .tlp_valid(ep_link.tlp_valid), .tlp_ready(ep_link.tlp_ready),
		.tlp_kind(ep_link.tlp_kind), .tlp_addr(ep_link.tlp_addr), .tlp_data(ep_link.tlp_data),
		.rx_valid(ep_link.rx_valid), .rx_malformed(ep_link.rx_malformed));

	always #2.5 sys_clk_i = ~sys_clk_i;
	// Far side stalls at random
	always @(posedge sys_clk_i) tlp_ready_i <= 1'($urandom_range(0, 1));

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (ep_seen === 1'b1) begin
			if (tq.size() == 0) `CHK(ep_seen, 1'b0)
			else begin
				e = tq.pop_front();
				if (e[50]) `CHK(ep_kind, e[49:48])
				else `CHK({ep_kind, ep_addr, ep_data}, e[49:0])
			end
		end
		if ((sel_rc ? rc_ack : ep_ack) === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
			r = rq.pop_front();
			`CHK((sel_rc ? rc_dat : ep_dat) & r[63:32], r[31:0])
		end
		if (rc_seen === 1'b1) n_rc_seen++;
		if (rc_link.mp_strobe === 1'b1) n_strobe++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic timeout();
		n_fail++;
		wrap_up();
	endtask
	task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		int i;
		@(posedge sys_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		for (i = 0; i < 20 && (sel_rc ? rc_ack : ep_ack) !== 1'b1; i++) @(posedge sys_clk_i);
		if (i == 20) timeout();
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
		rq.push_back({msk, exp});
		wb_io(1'b0, adr, 32'h0, 4'hF);
	endtask
	task automatic wait_empty();
		int i;
		for (i = 0; i < 200 && tq.size() > 0; i++) @(posedge sys_clk_i);
		if (tq.size() > 0) timeout();
	endtask
	task automatic wait_served();
		int i;
		for (i = 0; i < 100 && ep_served !== 1'b1; i++) @(posedge sys_clk_i);
		if (i == 100) timeout();
	endtask
	task automatic rx_pulse(input logic [3:0] k);
		@(posedge sys_clk_i);
		rx_valid_i <= 1'b1;
		{rx_poison_i, rx_memreq_i, rx_malformed_i, rx_msi_i} <= k;
		@(posedge sys_clk_i);
		rx_valid_i <= 1'b0;
		{rx_poison_i, rx_memreq_i, rx_malformed_i, rx_msi_i} <= 4'h0;
		repeat (4) @(posedge sys_clk_i);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h84c8));
		repeat (4) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rd(BISIG_ADR_DECODE, 32'h0, 32'hFFFFFFFF);
		rd(BISIG_ADR_MASK, 32'h0, 32'hFFFFFFFF);
		rd(8'h20, 32'h0, 32'hFFFFFFFF);
		rp_msi_addr_i <= $urandom;
		rp_msi_data_i <= 16'($urandom);
		rp_msi_en_i <= 1'b1;
		rp_err_rep_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rd(BISIG_ADR_STATUS, 32'h04, 32'h3D);
		for (int c = 0; c < 8; c++) begin
			rp_mme_i <= 3'(c);
			repeat (4) @(posedge sys_clk_i);
			`CHK(ep_link.msi_vec_width, 3'(c))
			`CHK(ep_link.msg_ctrl[6:1], {3'(c), 3'h5})
			v = $urandom_range(0, 31);
			m = (c <= 5) ? 5'((32'h1 << c) - 1) : 5'h0;
			tq.push_back({1'b0, BISIG_TLP_MSI_WR, rp_msi_addr_i, rp_msi_data_i[15:5], (rp_msi_data_i[4:0] & ~m) | (5'(v) & m)});
			user_pend_i <= 32'h1 << v;
			wait_served();
			user_pend_i <= 32'h0;
			wait_empty();
		end
		rp_msi_en_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		tq.push_back({1'b1, BISIG_TLP_ASSERT_INTA, 48'h0});
		user_intx_i <= 1'b1;
		wait_empty();
		tq.push_back({1'b1, BISIG_TLP_DEASSERT_INTA, 48'h0});
		user_intx_i <= 1'b0;
		wait_empty();
		wb_io(1'b1, BISIG_ADR_MASK, 32'h7, 4'hF);
		wb_io(1'b1, BISIG_ADR_MASK, 32'h0, 4'h0);
		rd(BISIG_ADR_MASK, 32'h7, 32'hFFFFFFFF);
		tq.push_back({1'b1, BISIG_TLP_FATAL_ERR, 48'h0});
		rx_pulse(4'b0010);
		wait_empty();
		`CHK(ep_irq, 1'b1)
		rd(BISIG_ADR_DECODE, 32'h4, 32'h7);
		wb_io(1'b1, BISIG_ADR_DECODE, 32'h4, 4'hF);
		rd(BISIG_ADR_DECODE, 32'h0, 32'h7);
		`CHK(ep_irq, 1'b0)
		rp_err_rep_i <= 1'b0;
		rx_pulse(4'b0010);
		rd(BISIG_ADR_DECODE, 32'h0, 32'h4);
		rx_pulse(4'b1100);
		rx_pulse(4'b1000);
		rx_pulse(4'b0001);
		rd(BISIG_ADR_DECODE, 32'h0, 32'h2);
		sel_rc <= 1'b1;
		rd(BISIG_ADR_DECODE, 32'h3, 32'h3);
		rd(BISIG_ADR_STATUS, 32'h1, 32'h5);
		`CHK(rc_irq, 1'b1)
		`CHK(n_strobe, 1)
		`CHK(n_rc_seen, 0)
		wrap_up();
	end
endmodule
